// ---- logic/msrb_regs.vh ----
// Register indices, field positions and reset values of the model-specific register bank
`ifndef MSRB_REGS_VH
`define MSRB_REGS_VH

// Register indices, as seen on the register port
`define MSRB_IDX_W            12
`define MSRB_STACK_INDEX      12'h1c9
`define MSRB_FEATURE_MISC     12'h1a0
`define MSRB_DEBUG_CONTROL    12'h1d9
`define MSRB_LER_TARGET       12'h1dd
`define MSRB_LER_SOURCE       12'h1de
`define MSRB_DEF_MEM_TYPE     12'h2ff
`define MSRB_BANK0_CTL        12'h400
`define MSRB_BANK0_STATUS     12'h401
`define MSRB_BANK0_ADDR       12'h402
`define MSRB_BANK1_CTL        12'h404
`define MSRB_BANK1_STATUS     12'h405
`define MSRB_BANK1_ADDR       12'h406
`define MSRB_EVENT_STATUS     12'h7f0
`define MSRB_EVENT_MASK       12'h7f1

// Feature-enable fields
`define MSRB_FE_PERF_MON      7
`define MSRB_FE_ERR_MUX       10
`define MSRB_FE_NO_TRACE      11
`define MSRB_FE_NO_SAMPLING   12
`define MSRB_FE_FREQ_SCALE    16

// Debug-control fields
`define MSRB_DBG_RECORD       0

// Machine-check status fields
`define MSRB_MC_VALID         63
`define MSRB_MC_ADDR_VALID    58
`define MSRB_MC_CODE_W        16

// Event status bits
`define MSRB_EV_W             3
`define MSRB_EV_EXCEPTION     0
`define MSRB_EV_BANK0         1
`define MSRB_EV_BANK1         2

// Reset values
`define MSRB_RST_64           64'h0000000000000000
`define MSRB_RST_EV           3'h0
`define MSRB_RST_INDEX        4'h0

`endif

// ---- logic/msrb_check_bank.v ----
// One machine-check bank: control, status and error address
`timescale 1ns/1ps
`include "msrb_regs.vh"

module msrb_check_bank #(
  parameter ADDR_W = 36
) (
  input  wire                        mclk,
  input  wire                        srst,
  input  wire                        wr_ctl,
  input  wire                        wr_status,
  input  wire [63:0]                 wdata,
  input  wire                        err_event,
  input  wire [`MSRB_MC_CODE_W-1:0]  err_code,
  input  wire                        err_addr_valid,
  input  wire [ADDR_W-1:0]           err_addr,
  output reg  [63:0]                 ctl,
  output reg  [63:0]                 status,
  output wire [63:0]                 addr_view
);

  reg [ADDR_W-1:0] addr_q;

  always @(posedge mclk) begin
    if (srst) begin
      ctl    <= `MSRB_RST_64;
      status <= `MSRB_RST_64;
      addr_q <= {ADDR_W{1'b0}};
    end else begin
      if (wr_ctl) begin
        ctl <= wdata;
      end
      // A hardware error wins over a software write in the same cycle
      if (err_event) begin
        status <= `MSRB_RST_64;
        status[`MSRB_MC_VALID] <= 1'b1;
        status[`MSRB_MC_ADDR_VALID] <= err_addr_valid;
        status[`MSRB_MC_CODE_W-1:0] <= err_code;
        if (err_addr_valid) begin
          addr_q <= err_addr;
        end
      end else if (wr_status) begin
        status <= wdata;
      end
    end
  end

  assign addr_view = status[`MSRB_MC_ADDR_VALID] ? {{(64-ADDR_W){1'b0}}, addr_q} : `MSRB_RST_64;

endmodule

// ---- logic/msrb_bank.v ----
// Model-specific register bank: feature enables, branch records, memory type, machine check
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "msrb_regs.vh"

module msrb_bank #(
  parameter IP_W        = 32,
  parameter MC_ADDR_W   = 36,
  parameter INDEX_W     = 4,
  parameter TRACE_ABSENT = 1,
  parameter BANK0_ADDR  = 1,
  parameter BANK1_ADDR  = 1
) (
  input  wire                        mclk,
  input  wire                        srst,
  input  wire [`MSRB_IDX_W-1:0]      reg_addr,
  input  wire [63:0]                 reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [63:0]                 reg_rdata,
  output reg                         reg_fault,
  input  wire                        perf_mon_enabled,
  input  wire                        freq_scale_locked,
  input  wire                        fp_error,
  input  wire                        break_pending,
  input  wire                        branch_taken,
  input  wire [IP_W-1:0]             branch_source_ip,
  input  wire [IP_W-1:0]             branch_target_ip,
  input  wire                        exception_event,
  input  wire                        mc0_error,
  input  wire [`MSRB_MC_CODE_W-1:0]  mc0_code,
  input  wire                        mc0_addr_valid,
  input  wire [MC_ADDR_W-1:0]        mc0_addr,
  input  wire                        mc1_error,
  input  wire [`MSRB_MC_CODE_W-1:0]  mc1_code,
  input  wire                        mc1_addr_valid,
  input  wire [MC_ADDR_W-1:0]        mc1_addr,
  output reg                         float_error_pin,
  output reg                         freq_scale_en,
  output reg  [63:0]                 debug_control,
  output reg  [63:0]                 default_memory_type,
  output reg                         irq
);

  // Decoded access strobes
  wire wr_feature;
  wire wr_debug;
  wire wr_memtype;
  wire wr_b0_ctl;
  wire wr_b0_status;
  wire wr_b1_ctl;
  wire wr_b1_status;
  wire wr_ev_mask;
  wire rd_ev_status;

  // Feature-enable state: two writable bits and the registered monitor input
  reg             err_mux;
  reg             freq_scale;
  reg             perf_mon_q;

  // Branch recording
  reg [INDEX_W-1:0] stack_top_index;
  reg [IP_W-1:0]    last_source;
  reg [IP_W-1:0]    last_target;
  reg [IP_W-1:0]    ler_source;
  reg [IP_W-1:0]    ler_target;

  // Event status and mask
  reg [`MSRB_EV_W-1:0] ev_status;
  reg [`MSRB_EV_W-1:0] ev_mask;
  reg [`MSRB_EV_W-1:0] next_ev_status;

  // Machine-check banks
  wire [63:0] b0_ctl;
  wire [63:0] b0_status;
  wire [63:0] b0_addr;
  wire [63:0] b1_ctl;
  wire [63:0] b1_status;
  wire [63:0] b1_addr;

  // Read path
  reg [63:0] next_rdata;
  reg        next_fault;
  reg        mapped;

  wire [63:0] feature_view;

  // Widen an instruction pointer to a full register
  function [63:0] widen_ip;
    input [IP_W-1:0] ip;
    begin
      widen_ip = {{(64-IP_W){1'b0}}, ip};
    end
  endfunction

  // True for a bank address index that the build leaves out
  function addr_missing;
    input [`MSRB_IDX_W-1:0] idx;
    begin
      addr_missing = ((idx == `MSRB_BANK0_ADDR) && (BANK0_ADDR == 0)) ||
                     ((idx == `MSRB_BANK1_ADDR) && (BANK1_ADDR == 0));
    end
  endfunction

  assign wr_feature   = reg_wr && (reg_addr == `MSRB_FEATURE_MISC);
  assign wr_debug     = reg_wr && (reg_addr == `MSRB_DEBUG_CONTROL);
  assign wr_memtype   = reg_wr && (reg_addr == `MSRB_DEF_MEM_TYPE);
  assign wr_b0_ctl    = reg_wr && (reg_addr == `MSRB_BANK0_CTL);
  assign wr_b0_status = reg_wr && (reg_addr == `MSRB_BANK0_STATUS);
  assign wr_b1_ctl    = reg_wr && (reg_addr == `MSRB_BANK1_CTL);
  assign wr_b1_status = reg_wr && (reg_addr == `MSRB_BANK1_STATUS);
  assign wr_ev_mask   = reg_wr && (reg_addr == `MSRB_EVENT_MASK);
  assign rd_ev_status = reg_rd && (reg_addr == `MSRB_EVENT_STATUS);

  assign feature_view = {47'h0,
                         freq_scale,
                         3'h0,
                         1'b1,
                         (TRACE_ABSENT != 0),
                         err_mux,
                         2'h0,
                         perf_mon_q,
                         7'h00};

  // Feature-enable and control registers
  always @(posedge mclk) begin
    if (srst) begin
      err_mux             <= 1'b0;
      freq_scale          <= 1'b0;
      perf_mon_q          <= 1'b0;
      debug_control       <= `MSRB_RST_64;
      default_memory_type <= `MSRB_RST_64;
      ev_mask             <= `MSRB_RST_EV;
    end else begin
      perf_mon_q <= perf_mon_enabled;
      if (wr_feature) begin
        err_mux <= reg_wdata[`MSRB_FE_ERR_MUX];
        if (!freq_scale_locked) begin
          freq_scale <= reg_wdata[`MSRB_FE_FREQ_SCALE];
        end
      end
      if (wr_debug) begin
        debug_control <= reg_wdata;
      end
      if (wr_memtype) begin
        default_memory_type <= reg_wdata;
      end
      if (wr_ev_mask) begin
        ev_mask <= reg_wdata[`MSRB_EV_W-1:0];
      end
    end
  end

  // Pins that the feature bits steer
  always @(posedge mclk) begin
    if (srst) begin
      float_error_pin <= 1'b0;
      freq_scale_en   <= 1'b0;
    end else begin
      if (err_mux) begin
        float_error_pin <= break_pending;
      end else begin
        float_error_pin <= fp_error;
      end
      freq_scale_en <= freq_scale;
    end
  end

  // Branch records; exception capture reads the branch already recorded,
  // so a branch in the same cycle as the exception is not counted before it
  always @(posedge mclk) begin
    if (srst) begin
      stack_top_index <= {INDEX_W{1'b0}};
      last_source     <= {IP_W{1'b0}};
      last_target     <= {IP_W{1'b0}};
      ler_source      <= {IP_W{1'b0}};
      ler_target      <= {IP_W{1'b0}};
    end else begin
      if (branch_taken && debug_control[`MSRB_DBG_RECORD]) begin
        stack_top_index <= stack_top_index + {{(INDEX_W-1){1'b0}}, 1'b1};
        last_source     <= branch_source_ip;
        last_target     <= branch_target_ip;
      end
      if (exception_event && debug_control[`MSRB_DBG_RECORD]) begin
        ler_target <= last_target;
        ler_source <= last_source;
      end
    end
  end

  // Machine-check banks on four-index strides
  // bank 0 at 400h
  msrb_check_bank #(
    .ADDR_W         (MC_ADDR_W)
  ) u_bank0 (
    .mclk           (mclk),
    .srst           (srst),
    .wr_ctl         (wr_b0_ctl),
    .wr_status      (wr_b0_status),
    .wdata          (reg_wdata),
    .err_event      (mc0_error),
    .err_code       (mc0_code),
    .err_addr_valid (mc0_addr_valid),
    .err_addr       (mc0_addr),
    .ctl            (b0_ctl),
    .status         (b0_status),
    .addr_view      (b0_addr)
  );

  msrb_check_bank #(
    .ADDR_W         (MC_ADDR_W)
  ) u_bank1 (
    .mclk           (mclk),
    .srst           (srst),
    .wr_ctl         (wr_b1_ctl),
    .wr_status      (wr_b1_status),
    .wdata          (reg_wdata),
    .err_event      (mc1_error),
    .err_code       (mc1_code),
    .err_addr_valid (mc1_addr_valid),
    .err_addr       (mc1_addr),
    .ctl            (b1_ctl),
    .status         (b1_status),
    .addr_view      (b1_addr)
  );

  // Sticky events; a new event beats the clear-on-read
  always @* begin
    next_ev_status = ev_status;
    if (rd_ev_status) begin
      next_ev_status = `MSRB_RST_EV;
    end
    if (exception_event && debug_control[`MSRB_DBG_RECORD]) begin
      next_ev_status[`MSRB_EV_EXCEPTION] = 1'b1;
    end
    if (mc0_error) begin
      next_ev_status[`MSRB_EV_BANK0] = 1'b1;
    end
    if (mc1_error) begin
      next_ev_status[`MSRB_EV_BANK1] = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      ev_status <= `MSRB_RST_EV;
      irq       <= 1'b0;
    end else begin
      ev_status <= next_ev_status;
      irq       <= |(next_ev_status & ev_mask);
    end
  end

  // Read mux
  always @* begin
    next_rdata = `MSRB_RST_64;
    mapped     = 1'b1;
    case (reg_addr)
      `MSRB_FEATURE_MISC: begin
        next_rdata = feature_view;
      end
      `MSRB_STACK_INDEX: begin
        next_rdata = {{(64-INDEX_W){1'b0}}, stack_top_index};
      end
      `MSRB_DEBUG_CONTROL: begin
        next_rdata = debug_control;
      end
      `MSRB_LER_TARGET: begin
        next_rdata = widen_ip(ler_target);
      end
      `MSRB_LER_SOURCE: begin
        next_rdata = widen_ip(ler_source);
      end
      `MSRB_DEF_MEM_TYPE: begin
        next_rdata = default_memory_type;
      end
      `MSRB_BANK0_CTL: begin
        next_rdata = b0_ctl;
      end
      `MSRB_BANK0_STATUS: begin
        next_rdata = b0_status;
      end
      `MSRB_BANK0_ADDR: begin
        next_rdata = b0_addr;
      end
      `MSRB_BANK1_CTL: begin
        next_rdata = b1_ctl;
      end
      `MSRB_BANK1_STATUS: begin
        next_rdata = b1_status;
      end
      `MSRB_BANK1_ADDR: begin
        next_rdata = b1_addr;
      end
      `MSRB_EVENT_STATUS: begin
        next_rdata = {61'h0, ev_status};
      end
      `MSRB_EVENT_MASK: begin
        next_rdata = {61'h0, ev_mask};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    next_fault = (reg_rd || reg_wr) && (!mapped || addr_missing(reg_addr));
    if (!reg_rd || next_fault) begin
      next_rdata = `MSRB_RST_64;
    end
  end

  // Answer in the cycle after the strobe; the slave never stalls
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= `MSRB_RST_64;
      reg_fault <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_fault <= next_fault;
    end
  end

endmodule

// ---- bench/msrb_bank_asserts.sv ----
// Port checker for the register bank
`timescale 1ns/1ps
`include "msrb_regs.vh"
module msrb_bank_asserts #(
  parameter TRACE_ABSENT = 1,
  parameter BANK1_ADDR = 1
) (
  input wire        mclk,
  input wire        srst,
  input wire [11:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [63:0] reg_rdata,
  input wire        reg_fault,
  input wire        freq_scale_locked,
  input wire        fp_error,
  input wire        break_pending,
  input wire        float_error_pin,
  input wire        freq_scale_en,
  input wire [63:0] debug_control,
  input wire [63:0] default_memory_type
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  reg  h10;
  reg  h16;
  wire fe = reg_addr == `MSRB_FEATURE_MISC;
  wire mux = h10 ? break_pending : fp_error;
  // Shadow of the two writable feature bits; the lock input gates bit 16
  always @(posedge mclk) begin
    if (srst) begin
      h10 <= 1'b0;
      h16 <= 1'b0;
    end else if (reg_wr && fe) begin
      h10 <= reg_wdata[10];
      if (!freq_scale_locked) h16 <= reg_wdata[16];
    end
  end
  a_fault_zero_data: assert property (
    reg_fault |-> reg_rdata == 64'h0) else $error("data beside fault");
  a_bank1_missing: assert property (
    (reg_rd || reg_wr) && reg_addr == `MSRB_BANK1_ADDR && BANK1_ADDR == 0 |=> reg_fault)
    else $error("absent address register did not fault");
  a_unmapped_fault: assert property (
    (reg_rd || reg_wr) && reg_addr[11] |=> reg_fault) else $error("unmapped index no fault");
  a_ro_write_quiet: assert property (
    reg_wr && (reg_addr == 12'h1c9 || reg_addr == 12'h1dd || reg_addr == 12'h1de)
    |=> !reg_fault) else $error("read-only write faulted");
  a_feature_fixed: assert property (
    reg_rd && fe |=> reg_rdata[12] && reg_rdata[11] == (TRACE_ABSENT != 0)
    && (reg_rdata & ~64'h11c80) == 64'h0) else $error("feature fixed bits wrong");
  a_feature_rw: assert property (
    reg_rd && fe |=> reg_rdata[10] == $past(h10) && reg_rdata[16] == $past(h16))
    else $error("feature writable bits wrong");
  a_float_select: assert property (
    float_error_pin == $past(mux)) else $error("error pin source wrong");
  a_freq_follow: assert property (
    freq_scale_en == $past(h16)) else $error("scaling enable wrong");
  a_debug_write: assert property (
    reg_wr && reg_addr == `MSRB_DEBUG_CONTROL |=> debug_control == $past(reg_wdata))
    else $error("debug control not written");
  a_memtype_write: assert property (
    reg_wr && reg_addr == `MSRB_DEF_MEM_TYPE |=> default_memory_type == $past(reg_wdata))
    else $error("memory type not written");
  a_data_after_read: assert property (
    reg_rdata != 64'h0 |-> $past(reg_rd)) else $error("read data without read");
endmodule
bind msrb_bank msrb_bank_asserts #(.TRACE_ABSENT(TRACE_ABSENT), .BANK1_ADDR(BANK1_ADDR)) u_chk (
  .mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_fault,
  .freq_scale_locked, .fp_error, .break_pending, .float_error_pin, .freq_scale_en,
  .debug_control, .default_memory_type);

// ---- bench/tb_top.sv ----
// Self-checking bench for the register bank
`timescale 1ns/1ps
`include "msrb_regs.vh"
module tb_top;
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg  [11:0] reg_addr = 12'h0;
  reg  [63:0] reg_wdata = 64'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         perf_mon_enabled = 1'b1;
  reg         freq_scale_locked = 1'b0;
  reg         fp_error = 1'b0;
  reg         break_pending = 1'b0;
  reg         branch_taken = 1'b0;
  reg  [31:0] branch_source_ip = 32'h0;
  reg  [31:0] branch_target_ip = 32'h0;
  reg         exception_event = 1'b0;
  reg         mc0_error = 1'b0;
  reg         mc1_error = 1'b0;
  reg  [15:0] code = 16'h0;
  reg  [35:0] ma = 36'h0;
  wire [63:0] reg_rdata;
  wire [63:0] dbg;
  wire [63:0] mt;
  wire        reg_fault;
  wire        fpin;
  wire        fsen;
  wire        irq;
  reg  [65:0] expq [$];
  reg  [65:0] e;
  reg  [63:0] r;
  reg         rq = 1'b0;
  reg  [11:0] zl [0:11] = '{12'h1c9, 12'h1dd, 12'h1de, 12'h1d9, 12'h2ff, 12'h400,
                            12'h401, 12'h402, 12'h404, 12'h405, 12'h7f0, 12'h7f1};
  int         fail_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         i;
  msrb_bank #(.TRACE_ABSENT(1), .BANK0_ADDR(1), .BANK1_ADDR(0)) dut (
    .mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_fault,
    .perf_mon_enabled, .freq_scale_locked, .fp_error, .break_pending, .branch_taken,
    .branch_source_ip, .branch_target_ip, .exception_event,
    .mc0_error, .mc0_code(code), .mc0_addr_valid(1'b1), .mc0_addr(ma),
    .mc1_error, .mc1_code(code), .mc1_addr_valid(1'b0), .mc1_addr(ma),
    .float_error_pin(fpin), .freq_scale_en(fsen), .debug_control(dbg),
    .default_memory_type(mt), .irq);
  always #20 mclk = ~mclk;
  task chk(input [63:0] x, input [63:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        fail_count = fail_count + 1;
        $display("BAD %0t exp %h got %h", $time, x, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // One strobe; for a read d is the expected data, f the expected fault
  task acc(input w, input [11:0] a, input [63:0] d, input f);
    begin
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      expq.push_back({!w, f, d});
      @(posedge mclk);
    end
  endtask
  task gap(input int n);
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge mclk);
    end
  endtask
  function [63:0] fx(input b10, input b16, input p);
    fx = {47'h0, b16, 3'h0, 2'h3, b10, 2'h0, p, 7'h0};
  endfunction
  // Results are checked one cycle after each strobe, oldest note first
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (rq) begin
      e = expq.pop_front();
      chk(e[64], reg_fault);
      if (e[65]) chk(e[63:0], reg_rdata);
    end
    rq <= reg_rd | reg_wr;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  initial begin
    void'($urandom(4588));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    // The monitor bit lags its input by one cycle after reset
    gap(1);
    acc(0, 12'h1a0, fx(0, 0, 1), 0);
    for (i = 0; i < 12; i++) acc(0, zl[i], 64'h0, 0);
    r = {$urandom, $urandom};
    for (i = 0; i < 3; i++) acc(1, zl[i], r, 0);
    for (i = 0; i < 3; i++) acc(0, zl[i], 64'h0, 0);
    acc(1, 12'h1a0, r, 0);
    acc(0, 12'h1a0, fx(r[10], r[16], 1), 0);
    freq_scale_locked <= 1'b1;
    acc(1, 12'h1a0, ~r, 0);
    acc(0, 12'h1a0, fx(~r[10], r[16], 1), 0);
    freq_scale_locked <= 1'b0;
    perf_mon_enabled <= 1'b0;
    gap(3);
    acc(0, 12'h1a0, fx(~r[10], r[16], 0), 0);
    break_pending <= 1'b1;
    acc(1, 12'h1a0, 64'h10400, 0);
    gap(3);
    chk(1, fpin);
    chk(1, fsen);
    fp_error <= 1'b1;
    break_pending <= 1'b0;
    gap(3);
    chk(0, fpin);
    acc(1, 12'h1a0, 64'h0, 0);
    gap(3);
    chk(1, fpin);
    chk(0, fsen);
    r[0] = 1'b1;
    acc(1, 12'h1d9, r, 0);
    acc(1, 12'h2ff, ~r, 0);
    acc(0, 12'h1d9, r, 0);
    acc(0, 12'h2ff, ~r, 0);
    gap(1);
    chk(r, dbg);
    chk(~r, mt);
    for (i = 0; i < 3; i++) begin
      branch_taken <= 1'b1;
      branch_source_ip <= $urandom;
      branch_target_ip <= $urandom;
      @(posedge mclk);
    end
    branch_taken <= 1'b0;
    exception_event <= 1'b1;
    @(posedge mclk);
    exception_event <= 1'b0;
    gap(3);
    chk(0, irq);
    acc(0, 12'h1c9, 64'h3, 0);
    acc(0, 12'h1dd, branch_target_ip, 0);
    acc(0, 12'h1de, branch_source_ip, 0);
    acc(1, 12'h1d9, 64'h0, 0);
    branch_taken <= 1'b1;
    gap(2);
    branch_taken <= 1'b0;
    acc(0, 12'h1c9, 64'h3, 0);
    acc(1, 12'h7f1, 64'h1, 0);
    gap(3);
    chk(1, irq);
    acc(0, 12'h7f0, 64'h1, 0);
    gap(3);
    chk(0, irq);
    code <= r[15:0];
    ma <= r[51:16];
    mc0_error <= 1'b1;
    mc1_error <= 1'b1;
    @(posedge mclk);
    mc0_error <= 1'b0;
    mc1_error <= 1'b0;
    gap(3);
    chk(0, irq);
    acc(0, 12'h401, {1'b1, 4'h0, 1'b1, 42'h0, code}, 0);
    acc(0, 12'h402, {28'h0, ma}, 0);
    acc(0, 12'h405, {1'b1, 47'h0, code}, 0);
    acc(0, 12'h406, 64'h0, 1);
    acc(1, 12'h406, r, 1);
    acc(0, 12'h923, 64'h0, 1);
    acc(1, 12'h401, 64'h0, 0);
    acc(0, 12'h402, 64'h0, 0);
    acc(0, 12'h7f0, 64'h6, 0);
    gap(3);
    close_out;
  end
endmodule
